// file: sepc_pkg.sv
// Package of constants and types for the protected serial EEPROM controller
package sepc_pkg;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam int ADDR_W      = 6;
  localparam int DATA_W      = 16;
  localparam int WORDS       = 64;
  localparam int PAGE_WORDS  = 4;
  localparam int HDR_BITS    = 8;
  localparam int PREG_BITS   = 9;

  // ****************************************
  // Opcodes and extended address codes
  // ****************************************
  localparam logic [1:0] OP_EXT   = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_PAGE  = 2'h3;
  localparam logic [1:0] EXT_LOCK = 2'h0;
  localparam logic [1:0] EXT_FILL = 2'h1;
  localparam logic [1:0] EXT_EN   = 2'h3;

  // ****************************************
  // Reset values and protect register codes
  // ****************************************
  localparam logic [5:0]  PREG_RESET = 6'h3f;
  localparam logic [5:0]  PREG_ALL   = 6'h3f;
  localparam logic [5:0]  PREG_FRZ   = 6'h00;
  localparam logic [15:0] MEM_RESET  = 16'hffff;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ        = 200;
  localparam int PROG_TIME_MS   = 10;                              // Ceiling on one programming cycle
  localparam int PROG_MAX_CYC   = PROG_TIME_MS * 1000 * CLK_MHZ;
  localparam int PROG_TIME_US   = 20;                              // Self-timed cycle length, inside the ceiling
  localparam int PROG_CYC       = PROG_TIME_US * CLK_MHZ;
  localparam int PROG_CNT_W     = 21;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic sel;
    logic sclk;
    logic din;
    logic wen_pin;
    logic pre_pin;
  } sepc_pins_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_HDR   = 3'b001,
    ST_DATA  = 3'b011,
    ST_READ  = 3'b010,
    ST_WAITS = 3'b110,
    ST_PROG  = 3'b111,
    ST_DONE  = 3'b101
  } sepc_state_type;

endpackage

// file: sepc_core.sv
// Protected serial EEPROM instruction decoder, protect logic and self-timed programming
`timescale 1ns/1ps
module sepc_core (
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire sepc_pkg::sepc_pins_type pins,
  output logic                         dout,
  output logic                         dout_en_n,
  output logic                         busy,
  output logic                         write_enabled,
  output logic [5:0]                   protect_addr,
  output logic                         protect_flag,
  output logic                         protect_locked
);
  import sepc_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  sepc_pins_type meta_reg;
  sepc_pins_type sync_reg;
  logic          sclk_d_reg;

  // Two flops on every pin, then edge history of the serial clock only
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg   <= '0;
      sync_reg   <= '0;
      sclk_d_reg <= 1'b0;
    end else begin
      meta_reg   <= pins;
      sync_reg   <= meta_reg;
      sclk_d_reg <= sync_reg.sclk;
    end
  end

  wire sel_s   = sync_reg.sel;
  wire rise    = sync_reg.sclk & ~sclk_d_reg;
  wire bit_in  = sync_reg.din;
  wire w_pin   = sync_reg.wen_pin;
  wire pr_pin  = sync_reg.pre_pin;

  // ****************************************
  // State
  // ****************************************
  sepc_state_type state_reg, state_next;
  logic [DATA_W-1:0] mem [WORDS];
  logic [7:0]        hdr_reg;
  logic [3:0]        hcnt_reg;
  logic [4:0]        bcnt_reg;
  logic [15:0]       sh_reg;
  logic [5:0]        addr_reg;
  logic [1:0]        pcnt_reg;
  logic [15:0]       pbuf_reg [PAGE_WORDS];
  logic              wen_reg;
  logic              unlock_reg;
  logic              armed_reg;
  logic              lock_reg;
  logic [5:0]        preg_reg;
  logic              pflag_reg;
  logic              dout_reg;
  logic              dvalid_reg;
  logic              is_preg_rd_reg;
  logic              fill_reg;
  logic              page_reg;
  logic              bad_reg;
  logic [2:0]        nwords_reg;
  logic [PROG_CNT_W-1:0] tcnt_reg;

  // Header decode
  wire [1:0] op    = hdr_reg[7:6];
  wire [1:0] ext   = hdr_reg[5:4];
  wire [5:0] haddr = hdr_reg[5:0];
  wire hdr_done    = (state_reg == ST_HDR) && rise && (hcnt_reg == 4'(HDR_BITS - 1));
  wire [7:0] hdr_full = {hdr_reg[6:0], bit_in};
  wire [1:0] f_op  = hdr_full[7:6];
  wire [1:0] f_ext = hdr_full[5:4];
  wire is_read     = f_op == OP_READ;
  wire is_data     = (f_op == OP_WRITE && !pr_pin) || f_op == OP_PAGE && !pr_pin
                     || (f_op == OP_EXT && f_ext == EXT_FILL && !pr_pin);
  wire prot_hit    = haddr >= preg_reg && !pflag_reg;
  wire data_done   = (state_reg == ST_DATA) && rise && (bcnt_reg == 5'd15);
  wire [15:0] din_word = {sh_reg[14:0], bit_in};
  wire tdone       = tcnt_reg == PROG_CNT_W'(PROG_CYC - 1);

  // Next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (sel_s && rise && bit_in) state_next = ST_HDR;
      ST_HDR:   if (!sel_s) state_next = ST_IDLE;
                else if (hdr_done) state_next = is_read ? ST_READ : is_data ? ST_DATA : ST_WAITS;
      ST_DATA:  if (!sel_s) state_next = ST_WAITS;
      ST_READ:  if (!sel_s) state_next = ST_IDLE;
      ST_WAITS: if (!sel_s) state_next = ST_IDLE;
      ST_PROG:  if (tdone) state_next = ST_DONE;
      ST_DONE:  if (!sel_s) state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  // Programming start decision on select fall
  wire sel_fall_ok = !sel_s && (state_reg == ST_DATA || state_reg == ST_WAITS);
  wire do_write    = op == OP_WRITE && !pr_pin && wen_reg && nwords_reg == 3'd1 && !prot_hit;
  wire do_page     = op == OP_PAGE && !pr_pin && wen_reg && nwords_reg != 3'd0 && !bad_reg;
  wire do_fill     = op == OP_EXT && ext == EXT_FILL && !pr_pin && wen_reg && nwords_reg != 3'd0
                     && pflag_reg;
  wire pcmd_ok     = pr_pin && w_pin && armed_reg && !lock_reg;
  wire do_pstore   = op == OP_WRITE && pcmd_ok && state_reg == ST_WAITS;
  wire do_perase   = op == OP_PAGE && haddr == PREG_ALL && pcmd_ok;
  wire do_pfreeze  = op == OP_EXT && haddr == PREG_FRZ && pcmd_ok;
  wire start_prog  = sel_fall_ok && w_pin && (do_write || do_page || do_fill || do_pstore
                     || do_perase || do_pfreeze);

  // Main sequencing
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      hdr_reg <= '0; hcnt_reg <= '0; bcnt_reg <= '0; sh_reg <= '0;
      addr_reg <= '0; pcnt_reg <= '0; nwords_reg <= '0; bad_reg <= 1'b0;
      wen_reg <= 1'b0;
      unlock_reg <= 1'b0; lock_reg <= 1'b0;
      armed_reg <= 1'b0;
      preg_reg <= PREG_RESET; pflag_reg <= 1'b1;
      dout_reg <= 1'b1; dvalid_reg <= 1'b0; is_preg_rd_reg <= 1'b0;
      fill_reg <= 1'b0; page_reg <= 1'b0; tcnt_reg <= '0;
    end else begin
      state_reg <= start_prog ? ST_PROG : state_next;
      if (state_reg == ST_IDLE) begin
        hcnt_reg <= '0; bcnt_reg <= '0; nwords_reg <= '0; bad_reg <= 1'b0;
        dvalid_reg <= 1'b0; pcnt_reg <= '0;
      end
      // Header shift
      if (state_reg == ST_HDR && rise) begin
        hdr_reg  <= hdr_full;
        hcnt_reg <= hcnt_reg + 4'd1;
      end
      if (hdr_done) begin
        addr_reg <= hdr_full[5:0];
        // Any completed non-unlock instruction drops the protect unlock
        armed_reg  <= unlock_reg;                                     // Previous instruction was the unlock
        unlock_reg <= f_op == OP_EXT && f_ext == EXT_EN && pr_pin && w_pin && wen_reg;
        if (f_op == OP_EXT && f_ext == EXT_EN && !pr_pin && w_pin) wen_reg <= 1'b1;
        if (f_op == OP_EXT && f_ext == EXT_LOCK && !pr_pin) wen_reg <= 1'b0;
        if (is_read) begin
          is_preg_rd_reg <= pr_pin;
          sh_reg <= pr_pin ? {preg_reg, pflag_reg, 9'h000} : mem[hdr_full[5:0]];
          bcnt_reg <= '0;
          dout_reg <= 1'b0;
          dvalid_reg <= 1'b1;
        end
      end
      // Read shifting: change only after rising edge
      if (state_reg == ST_READ && rise) begin
        dout_reg <= sh_reg[15];
        sh_reg <= {sh_reg[14:0], 1'b0};
        if (bcnt_reg == 5'(is_preg_rd_reg ? PREG_BITS - 1 : DATA_W - 1)) begin
          bcnt_reg <= '0;
          addr_reg <= addr_reg + 6'd1;
          if (!is_preg_rd_reg) sh_reg <= mem[addr_reg + 6'd1];
        end else begin
          bcnt_reg <= bcnt_reg + 5'd1;
        end
      end
      // Data word capture
      if (state_reg == ST_DATA && rise) begin
        sh_reg <= din_word;
        bcnt_reg <= data_done ? 5'd0 : bcnt_reg + 5'd1;
      end
      if (data_done && nwords_reg != 3'(PAGE_WORDS)) begin
        pbuf_reg[pcnt_reg] <= din_word;
        nwords_reg <= nwords_reg + 3'd1;
        pcnt_reg <= pcnt_reg + 2'd1;
        if ({addr_reg[5:2], addr_reg[1:0] + pcnt_reg} >= preg_reg && !pflag_reg) bad_reg <= 1'b1;
      end
      // Programming start and commit
      if (start_prog) begin
        tcnt_reg <= '0;
        fill_reg <= do_fill;
        page_reg <= do_page || do_write;
        unlock_reg <= 1'b0;
        armed_reg <= 1'b0;
        if (do_pstore) begin preg_reg <= haddr; pflag_reg <= 1'b0; end
        if (do_perase) begin preg_reg <= PREG_ALL; pflag_reg <= 1'b1; end
        if (do_pfreeze) lock_reg <= 1'b1;
      end
      if (state_reg == ST_PROG) tcnt_reg <= tcnt_reg + PROG_CNT_W'(1);
      // Busy/ready on data out
      if (state_next == ST_DONE || state_reg == ST_DONE) dout_reg <= 1'b1;
      if (state_reg == ST_PROG) dout_reg <= 1'b0;
    end
  end

  // Array update, written at the end of the self-timed cycle
  always_ff @(posedge mclk) begin
    if (state_reg == ST_PROG && tdone) begin
      for (int i = 0; i < WORDS; i++) begin
        if (fill_reg) mem[i] <= pbuf_reg[0];
      end
      if (page_reg) begin
        for (int j = 0; j < PAGE_WORDS; j++) begin
          if (3'(j) < nwords_reg) mem[{addr_reg[5:2], addr_reg[1:0] + 2'(j)}] <= pbuf_reg[j];
        end
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire show_rdy   = sel_s && (state_reg == ST_PROG || state_reg == ST_DONE);
  assign dout       = dout_reg;
  assign dout_en_n  = !((state_reg == ST_READ && dvalid_reg) || show_rdy);
  assign busy       = state_reg == ST_PROG;
  assign write_enabled  = wen_reg;
  assign protect_addr   = preg_reg;
  assign protect_flag   = pflag_reg;
  assign protect_locked = lock_reg;

  // ****************************************
  // Assertions
  // ****************************************
  property p_reset_disabled;
    @(posedge mclk) $fell(sys_rst) |-> !wen_reg;
  endproperty
  a_reset_disabled: assert property (p_reset_disabled) else $error("write enable set after reset");

  property p_dout_on_rise;
    @(posedge mclk) disable iff (sys_rst) (state_reg == ST_READ && !rise && $stable(state_reg)) |=> $stable(dout_reg);
  endproperty
  a_dout_on_rise: assert property (p_dout_on_rise) else $error("data out moved without clock rise");

  property p_prog_len;
    @(posedge mclk) disable iff (sys_rst) busy |-> tcnt_reg < PROG_CNT_W'(PROG_MAX_CYC);
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("programming cycle too long");

  property p_busy_low;
    @(posedge mclk) disable iff (sys_rst) (busy && $past(busy)) |-> !dout;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy not shown low");

  property p_lock_sticky;
    @(posedge mclk) disable iff (sys_rst) lock_reg |=> lock_reg && $stable(preg_reg);
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("locked protect register changed");

  property p_no_start_disabled;
    @(posedge mclk) disable iff (sys_rst) (start_prog && !pr_pin) |-> wen_reg;
  endproperty
  a_no_start_disabled: assert property (p_no_start_disabled) else $error("write started while disabled");

  property p_erase_flag;
    @(posedge mclk) disable iff (sys_rst) (start_prog && do_perase) |=> pflag_reg && preg_reg == PREG_ALL;
  endproperty
  a_erase_flag: assert property (p_erase_flag) else $error("protect erase failed");

  property p_store_flag;
    @(posedge mclk) disable iff (sys_rst) (start_prog && do_pstore) |=> !pflag_reg && preg_reg == $past(haddr);
  endproperty
  a_store_flag: assert property (p_store_flag) else $error("protect store failed");

  property p_pcmd_armed;
    @(posedge mclk) disable iff (sys_rst) (start_prog && pr_pin) |-> armed_reg && !lock_reg;
  endproperty
  a_pcmd_armed: assert property (p_pcmd_armed) else $error("protect command ran without unlock");

  property p_ready_high;
    @(posedge mclk) disable iff (sys_rst) (state_reg == ST_DONE && $past(state_reg) == ST_DONE) |-> dout;
  endproperty
  a_ready_high: assert property (p_ready_high) else $error("ready not shown high");

  property p_busy_ignore;
    @(posedge mclk) disable iff (sys_rst) (busy && $past(busy)) |-> $stable(wen_reg) && $stable(unlock_reg);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("bus activity taken while busy");

  c_read:  cover property (@(posedge mclk) state_reg == ST_READ && bcnt_reg == 5'd15);
  c_prog:  cover property (@(posedge mclk) state_reg == ST_DONE);
  c_freeze: cover property (@(posedge mclk) $rose(lock_reg));
  c_store: cover property (@(posedge mclk) start_prog && do_pstore);
endmodule

// file: sepc_host.sv
// Host model that drives the serial pins of the protected EEPROM core
`timescale 1ns/1ps
module sepc_host (
  input  wire logic             mclk,
  input  wire logic             dout,
  output sepc_pkg::sepc_pins_type pins
);
  import sepc_pkg::*;

  // ****************************************
  // Pin timing in system clock cycles
  // ****************************************
  localparam int HALF = 100; // 500 ns per clock phase, 1 us period
  localparam int GAP  = 60;  // 300 ns select low between instructions

  // Pins idle with select and serial clock low
  initial begin
    pins = '0;
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  // Shifts the low n bits of tx MSB first and collects dout after each rise
  task automatic xfer(input logic w, input logic p, input logic [24:0] tx, input int n,
                      output logic [15:0] rx, output logic steady);
    logic q;
    rx = '0;
    steady = 1'b1;
    q = 1'b0;
    @(negedge mclk);
    pins.wen_pin = w;
    pins.pre_pin = p;
    pins.sel = 1'b1; // Select rises while serial clock is low
    for (int i = 0; i < n; i++) begin
      pins.din = tx[n-1-i];
      repeat (HALF) @(negedge mclk);
      if (i > 0 && dout !== q) begin
        steady = 1'b0; // Output moved during the low phase
      end
      pins.sclk = 1'b1;
      repeat (HALF) @(negedge mclk);
      pins.sclk = 1'b0;
      q = dout;
      rx = {rx[14:0], q};
    end
  endtask

  // Drops select; the released data line shows the inverse of its last value
  task automatic drop();
    @(negedge mclk);
    pins.sel = 1'b0;
    pins.din = ~pins.din;
    repeat (GAP) @(negedge mclk);
  endtask

  // Raises select alone to poll ready/busy
  task automatic raise();
    @(negedge mclk);
    pins.sel = 1'b1;
  endtask
endmodule

// file: tb.sv
// Self-checking testbench of the protected serial EEPROM core
`timescale 1ns/1ps
module tb;
  import sepc_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  localparam int LIMIT = 60000;
  logic          mclk;
  logic          sys_rst;
  sepc_pins_type pins;
  logic          dout;
  logic          dout_en_n;
  logic          busy;
  logic          write_enabled;
  logic [5:0]    protect_addr;
  logic          protect_flag;
  logic          protect_locked;
  logic [15:0]   rx;
  logic          steady;
  int            failures = 0;
  int            checked = 0;
  int            cycles = 0;

  sepc_core i_sepc_core (.mclk(mclk), .sys_rst(sys_rst), .pins(pins), .dout(dout), .dout_en_n(dout_en_n),
                         .busy(busy), .write_enabled(write_enabled), .protect_addr(protect_addr),
                         .protect_flag(protect_flag), .protect_locked(protect_locked));
  sepc_host i_sepc_host (.mclk(mclk), .dout(dout), .pins(pins));

  // Clock of 5 ns period
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures = failures + 1;
      summarize();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic [8:0] cmd [3];
    logic       ena [3];
    cmd = '{9'h130, 9'h100, 9'h130};
    ena = '{1'b1, 1'b0, 1'b1};
    sys_rst = 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    // Reset state
    check(16'(write_enabled), 16'h0000);
    check(16'(protect_addr), 16'h003f);
    check(16'(protect_flag), 16'h0001);
    check(16'(protect_locked), 16'h0000);
    check(16'(busy), 16'h0000);
    $display("test reset done");
    // Protect readout: dummy zero, six register ones, flag one
    i_sepc_host.xfer(1'b0, 1'b1, 25'h000c000, 16, rx, steady);
    check(16'(rx[7:0]), 16'h007f);
    check(16'(steady), 16'h0001);
    i_sepc_host.drop();
    $display("test protect readout done");
    // Write while writes are disabled is refused
    i_sepc_host.xfer(1'b1, 1'b0, 25'h143a5c3, 25, rx, steady);
    i_sepc_host.drop();
    repeat (10) @(negedge mclk);
    check(16'(busy), 16'h0000);
    $display("test refused write done");
    // Enable, disable, enable again
    for (int i = 0; i < 3; i++) begin
      i_sepc_host.xfer(1'b1, 1'b0, 25'(cmd[i]), 9, rx, steady);
      i_sepc_host.drop();
      check(16'(write_enabled), 16'(ena[i]));
    end
    $display("test write permission done");
    // Read: dummy zero first with output driven
    i_sepc_host.xfer(1'b0, 1'b0, 25'h0000185, 9, rx, steady);
    check(16'(rx[0]), 16'h0000);
    check(16'(dout_en_n), 16'h0000);
    i_sepc_host.drop();
    $display("test read done");
    // Accepted write starts programming; busy shown and bus ignored
    i_sepc_host.xfer(1'b1, 1'b0, 25'h143a5c3, 25, rx, steady);
    i_sepc_host.drop();
    check(16'(busy), 16'h0001);
    i_sepc_host.raise();
    repeat (10) @(negedge mclk);
    check(16'(dout), 16'h0000);
    check(16'(dout_en_n), 16'h0000);
    i_sepc_host.drop();
    i_sepc_host.xfer(1'b1, 1'b0, 25'h0000100, 9, rx, steady);
    i_sepc_host.drop();
    check(16'(write_enabled), 16'h0001);
    check(16'(busy), 16'h0001);
    $display("test busy write done");
    // Select held high across the end of programming shows ready
    i_sepc_host.raise();
    repeat (PROG_CYC) @(negedge mclk);
    check(16'(busy), 16'h0000);
    check(16'(dout), 16'h0001);
    check(16'(dout_en_n), 16'h0000);
    i_sepc_host.drop();
    // Read back the programmed word after the dummy zero
    i_sepc_host.xfer(1'b0, 1'b0, 25'h1830000, 25, rx, steady);
    check(rx, 16'ha5c3);
    check(16'(steady), 16'h0001);
    i_sepc_host.drop();
    $display("test ready and read back done");
    // Unlock then store 02: words 02 and up become protected
    i_sepc_host.xfer(1'b1, 1'b1, 25'h0000130, 9, rx, steady);
    i_sepc_host.drop();
    i_sepc_host.xfer(1'b1, 1'b1, 25'h0000142, 9, rx, steady);
    i_sepc_host.drop();
    check(16'(protect_addr), 16'h0002);
    check(16'(protect_flag), 16'h0000);
    repeat (PROG_CYC) @(negedge mclk);
    check(16'(busy), 16'h0000);
    i_sepc_host.xfer(1'b1, 1'b0, 25'h143a5c3, 25, rx, steady);
    i_sepc_host.drop();
    repeat (10) @(negedge mclk);
    check(16'(busy), 16'h0000);
    $display("test protect store done");
    summarize();
  end
endmodule
